// ### design/scp_consts.svh
// Constants of the signaling channel preprocessor: command nibbles,
// address byte fields, field positions, fill values and reset values.
// Assumes inclusion by its bare name from design files only.
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH

// ****************************************************
// Command byte layout
// ****************************************************
`define SCP_CMD_OP_HI 7
`define SCP_CMD_OP_LO 4
`define SCP_CMD_CODE_HI 3
`define SCP_CMD_CODE_LO 0
`define SCP_CMD_WR_CODE_DATA 4'h7
`define SCP_CMD_RD_DATA 4'h4
`define SCP_CMD_WR_TRISTATE 8'h60

// ****************************************************
// Address byte layout
// ****************************************************
`define SCP_ADDR_UP_BIT 7
`define SCP_ADDR_ODD_BIT 0

// ****************************************************
// Field positions and fill values
// ****************************************************
`define SCP_HS_HI 1
`define SCP_HS_LO 0
`define SCP_SIG6_HI 7
`define SCP_SIG6_LO 2
`define SCP_HS_IDLE 2'h3
`define SCP_SIG6_MASK 8'hfc
`define SCP_SIG8_MASK 8'hff
`define SCP_TRI_LSB_DRIVE_BIT 0
`define SCP_OE_UPPER 6'h3f
`define SCP_BYTE_RESET 8'h00
`define SCP_CODE_RESET 4'h0
`define SCP_PERIOD_RESET 4'h0

`endif

// ### design/scp_pkg.sv
// Types shared by the signaling channel preprocessor files.
// Assumes the constants header is included where numbers are needed.
package scp_pkg;

  // Control memory codes used by the preprocessed channel schemes
  typedef enum logic [3:0] {
    scp_code_unused = 4'h0,
    scp_code_sw64 = 4'h1,
    scp_code_pre_a = 4'ha,
    scp_code_pre_b = 4'hb
  } scp_code_type;

  // One control memory entry: code field and data field
  typedef struct packed {
    logic [3:0] code;
    logic [7:0] data;
  } scp_entry_type;

endpackage : scp_pkg

// ### design/scp_period.sv
// Programmable sampling period divider for upstream signaling.
// Assumes frame_start is a one-cycle pulse from frame timing on clk.
`timescale 1ns/10ps
`default_nettype none
`include "scp_consts.svh"

module scp_period #(
  parameter int PW = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic frame_start,
  input wire logic [PW-1:0] period,
  output logic sample_frame_q
);

  logic [PW-1:0] cnt_q;
  logic [PW-1:0] cnt_d;
  wire hit = (cnt_q >= period);

  if (PW < 1 || PW > 16) begin : g_bad_pw
    $error("scp_period: PW out of range");
  end

  // Counts frames; a sampling frame every period+1 frames
  assign cnt_d = hit ? '0 : cnt_q + PW'(1);

  // The level holds for the whole sampling frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      sample_frame_q <= 1'b0;
    end else if (frame_start) begin
      cnt_q <= cnt_d;
      sample_frame_q <= hit;
    end
  end

endmodule : scp_period
`default_nettype wire

// ### design/scp_last_look.sv
// Double last-look decision for one signaling sample.
// Assumes the caller stores actual and stable values between calls.
`timescale 1ns/10ps
`default_nettype none
`include "scp_consts.svh"

module scp_last_look (
  input wire logic [7:0] sample,
  input wire logic [7:0] actual,
  input wire logic [7:0] stable,
  input wire logic wide,
  output logic [7:0] masked,
  output logic change
);

  wire [7:0] mask = wide ? `SCP_SIG8_MASK : `SCP_SIG6_MASK;

  // Two agreeing samples that differ from the stable value are a change
  assign masked = sample & mask;
  assign change = (masked == (actual & mask))
    && (masked != (stable & mask));

endmodule : scp_last_look
`default_nettype wire

// ### design/scp_core.sv
// Signaling channel preprocessor: control memory, downstream assembly,
// upstream change detection and transparent PCM switching.
// Assumes slot strobes and bytes come from frame timing on clk; the
// monitor handler, PCM data memory and change report FIFO sit outside.
// The processor side is plain strobes with no bus protocol: a command
// acts on the register values standing when its strobe is taken.
//
// Contract
// - 6-bit scheme: even slot is monitor, odd is signaling plus handshake
// - Handshake protocol: monitor handler drives the two handshake bits
// - Non-handshake: handshake bits forced to one, readable via even entry; code forces ones on PCM slots only, even data bits 1:0 elsewhere
// - Each valid upstream change raises interrupt and pushes slot address
// - Upstream changes pass double last-look with programmable period
// - 6-bit codes: down 1010/1011, up 1010 actual and stable
// - 8-bit scheme: even slot feature control, odd slot signaling byte
// - 8-bit codes: down 1010/1011, up 1011 actual and stable
// - Odd entry code 0001 switches the slot transparently to PCM
// - Downstream transparent: PCM low bits ANDed with handshake bits
// - Upstream transparent: PCM low bits may float under tristate field
// - Command 0111 xxxx writes code and data of addressed entry
// - Command 0110 0000 writes tristate field of addressed PCM slot
// - Address byte: top bit selects upstream, bottom bit odd slot
`timescale 1ns/10ps
`default_nettype none
`include "scp_consts.svh"

module scp_core #(
  parameter int SLOT_AW = 7,
  parameter int PW = 4
) (
  input wire logic clk,
  input wire logic rst,
  // Memory access registers
  input wire logic data_reg_we,
  input wire logic [7:0] data_reg_wdata,
  input wire logic addr_reg_we,
  input wire logic [7:0] addr_reg_wdata,
  input wire logic command_reg_we,
  input wire logic [7:0] command_reg_wdata,
  output logic [7:0] read_data_q,
  output logic [7:0] mem_access_addr_reg_q,
  // Configuration
  input wire logic monitor_handshake_en,
  input wire logic [PW-1:0] sample_period,
  // Monitor feature handler side
  input wire logic [7:0] monitor_tx_byte,
  input wire logic [1:0] monitor_hs_bits,
  // Slot timing
  input wire logic frame_start,
  input wire logic slot_strobe,
  input wire logic [SLOT_AW-1:0] slot_index,
  input wire logic [7:0] up_byte,
  // Subscriber side downstream output
  output logic down_valid_q,
  output logic [7:0] down_byte_q,
  // PCM side
  output logic [7:0] pcm_down_ptr,
  input wire logic [7:0] pcm_down_byte,
  output logic pcm_up_valid_q,
  output logic [7:0] pcm_up_ptr_q,
  output logic [7:0] pcm_up_byte_q,
  output logic [7:0] pcm_up_oe_q,
  // Change report
  output logic change_push_q,
  output logic [7:0] change_slot_q,
  output logic change_irq_q
);

  // Two halves of 2**SLOT_AW entries: downstream below, upstream above
  localparam int DEPTH = 2 << SLOT_AW;
  localparam int IW = SLOT_AW + 1;
  // One tristate byte for every slot a pointer byte can name
  localparam int DMCF_DEPTH = 256;

  // ****************************************************
  // Elaboration checks
  // ****************************************************
  // The slot index shares the address byte with the half select bit
  if (SLOT_AW < 2 || SLOT_AW > 7) begin : g_bad_slot_aw
    $error("scp_core: SLOT_AW unsupported");
  end
  // The divider needs at least one bit and counts in at most sixteen
  if (PW < 1 || PW > 16) begin : g_bad_pw
    $error("scp_core: PW out of range");
  end

  // ****************************************************
  // Storage
  // ****************************************************
  // Each entry holds a code and a data byte; the even entry of a pair
  // picks its scheme, the odd one's code can switch it to PCM and its data holds pointer or state
  scp_pkg::scp_entry_type control_memory [DEPTH];
  // Written by command only; read on every upstream switched slot
  logic [7:0] data_memory_control_field [DMCF_DEPTH];
  logic [7:0] mem_access_data_reg_q;

  // ****************************************************
  // Processor access decode
  // ****************************************************
  // Commands act in the strobe's cycle; unknown nibbles do nothing
  wire [3:0] cmd_op = command_reg_wdata[`SCP_CMD_OP_HI:`SCP_CMD_OP_LO];
  wire [3:0] cmd_code = command_reg_wdata[`SCP_CMD_CODE_HI:`SCP_CMD_CODE_LO];
  wire cmd_wr_cm = command_reg_we && (cmd_op == `SCP_CMD_WR_CODE_DATA);
  wire cmd_rd_cm = command_reg_we && (cmd_op == `SCP_CMD_RD_DATA);
  wire cmd_wr_tri = command_reg_we
    && (command_reg_wdata == `SCP_CMD_WR_TRISTATE);
  // Upper bit picks the upstream half, lower slot bits include odd/even
  wire [IW-1:0] cpu_idx = {mem_access_addr_reg_q[`SCP_ADDR_UP_BIT],
    mem_access_addr_reg_q[SLOT_AW-1:0]};

  // ****************************************************
  // Downstream lookup
  // ****************************************************
  // Both entries of the pair are looked up whichever slot is strobed
  wire s_odd = slot_index[`SCP_ADDR_ODD_BIT];
  wire [SLOT_AW-1:0] even_slot = {slot_index[SLOT_AW-1:1], 1'b0};
  wire [SLOT_AW-1:0] odd_slot = {slot_index[SLOT_AW-1:1], 1'b1};
  scp_pkg::scp_entry_type dn_even;
  scp_pkg::scp_entry_type dn_odd;
  scp_pkg::scp_entry_type up_even;
  scp_pkg::scp_entry_type up_odd;
  // Four reads per slot: output byte and change check need all of them
  assign dn_even = control_memory[{1'b0, even_slot}];
  assign dn_odd = control_memory[{1'b0, odd_slot}];
  assign up_even = control_memory[{1'b1, even_slot}];
  assign up_odd = control_memory[{1'b1, odd_slot}];

  // Scheme of the pair follows the upstream even code; a pair whose two
  // upstream codes disagree is left alone, so a half-written pair during
  // reprogramming cannot raise a false change
  wire pre_even = (dn_even.code == scp_pkg::scp_code_pre_a);
  wire wide = (up_even.code == scp_pkg::scp_code_pre_b);
  wire narrow = (up_even.code == scp_pkg::scp_code_pre_a);
  wire transp = (dn_odd.code == scp_pkg::scp_code_sw64);
  wire up_transp = (up_odd.code == scp_pkg::scp_code_sw64);

  // Handshake bits from the handler, or idle ones without handshake
  wire [1:0] hs_bits = monitor_handshake_en ? monitor_hs_bits
    : `SCP_HS_IDLE;
  // Non-handshake lets the even entry supply the handshake positions
  wire [1:0] odd_lsbs = monitor_handshake_en ? monitor_hs_bits
    : dn_even.data[`SCP_HS_HI:`SCP_HS_LO];

  assign pcm_down_ptr = dn_odd.data;

  // Odd slot byte: signaling byte, 6-bit field plus handshake, or PCM
  // Switching wins so a stale signaling byte never reaches a PCM pair
  logic [7:0] odd_byte;
  always_comb begin
    if (transp) begin
      odd_byte = {pcm_down_byte[`SCP_SIG6_HI:`SCP_SIG6_LO],
        pcm_down_byte[`SCP_HS_HI:`SCP_HS_LO] & hs_bits};
    end else if (wide) begin
      odd_byte = dn_even.data;
    end else begin
      odd_byte = {dn_even.data[`SCP_SIG6_HI:`SCP_SIG6_LO], odd_lsbs};
    end
  end

  // Even slot carries the monitor or feature byte in both schemes
  wire [7:0] down_d = s_odd ? odd_byte : monitor_tx_byte;
  wire down_hit = slot_strobe && pre_even;

  // ****************************************************
  // Upstream change detection
  // ****************************************************
  // Sampling frame from the divider; the decision itself is combinational
  logic sample_frame_q;
  logic [7:0] sig_masked;
  logic sig_change;

  scp_period #(.PW(PW)) u_period (
    .clk(clk),
    .rst(rst),
    .frame_start(frame_start),
    .period(sample_period),
    .sample_frame_q(sample_frame_q)
  );

  scp_last_look u_look (
    .sample(up_byte),
    .actual(up_even.data),
    .stable(up_odd.data),
    .wide(wide),
    .masked(sig_masked),
    .change(sig_change)
  );

  // Signaling sits in the odd upstream slot of a preprocessed pair
  // Switched pairs are skipped: their odd entry holds a pointer, not state
  wire sig_slot = slot_strobe && s_odd && !up_transp
    && (wide || narrow) && (up_odd.code == up_even.code);
  wire sig_sample = sig_slot && sample_frame_q;
  wire sig_report = sig_sample && sig_change;
  // Actual value lives in the even entry, stable value in the odd one
  wire [IW-1:0] act_idx = {1'b1, even_slot};
  wire [IW-1:0] stb_idx = {1'b1, odd_slot};

  // Processor writes land after the hardware updates, so they win
  // A sample and its report touch two separate entries of the pair, so
  // neither hardware write masks the other in a shared edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        control_memory[i] <= '{code: `SCP_CODE_RESET,
          data: `SCP_BYTE_RESET};
      end
    end else begin
      if (sig_sample) begin
        control_memory[act_idx].data <= sig_masked;
      end
      if (sig_report) begin
        control_memory[stb_idx].data <= sig_masked;
      end
      if (cmd_wr_cm) begin
        control_memory[cpu_idx] <= '{code: cmd_code,
          data: mem_access_data_reg_q};
      end
    end
  end

  // Tristate fields, one byte per PCM slot
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DMCF_DEPTH; i++) begin
        data_memory_control_field[i] <= `SCP_BYTE_RESET;
      end
    end else if (cmd_wr_tri) begin
      data_memory_control_field[mem_access_addr_reg_q] <=
        mem_access_data_reg_q;
    end
  end

  // ****************************************************
  // Access registers
  // ****************************************************
  // Registers keep their value, so several commands may share one byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_access_data_reg_q <= `SCP_BYTE_RESET;
      mem_access_addr_reg_q <= `SCP_BYTE_RESET;
      read_data_q <= `SCP_BYTE_RESET;
    end else begin
      if (data_reg_we) mem_access_data_reg_q <= data_reg_wdata;
      if (addr_reg_we) mem_access_addr_reg_q <= addr_reg_wdata;
      if (cmd_rd_cm) read_data_q <= control_memory[cpu_idx].data;
    end
  end

  // ****************************************************
  // Slot outputs
  // ****************************************************
  // Low two PCM bits float unless the tristate field drives them
  wire [7:0] tri_field = data_memory_control_field[up_odd.data];
  wire lsb_drive = tri_field[`SCP_TRI_LSB_DRIVE_BIT];
  // Upper six bits always driven; only the handshake positions may float
  wire [7:0] oe_word = {`SCP_OE_UPPER, {2{lsb_drive}}};
  // Odd slot of a pair whose upstream odd entry switches to the PCM side
  wire pcm_up_hit = slot_strobe && s_odd && up_transp;

  // Subscriber side: valid pulses one cycle, byte holds until the next
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      down_valid_q <= 1'b0;
      down_byte_q <= `SCP_BYTE_RESET;
    end else begin
      down_valid_q <= down_hit;
      if (down_hit) down_byte_q <= down_d;
    end
  end

  // PCM side: pointer, byte and enables are held for the outside memory
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pcm_up_valid_q <= 1'b0;
      pcm_up_ptr_q <= `SCP_BYTE_RESET;
      pcm_up_byte_q <= `SCP_BYTE_RESET;
      pcm_up_oe_q <= `SCP_BYTE_RESET;
    end else begin
      pcm_up_valid_q <= pcm_up_hit;
      if (pcm_up_hit) begin
        pcm_up_ptr_q <= up_odd.data;
        pcm_up_byte_q <= up_byte;
        pcm_up_oe_q <= oe_word;
      end
    end
  end

  // Change report: pulse with the subscriber slot address
  // Irq and push leave together, so the FIFO entry and interrupt agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      change_push_q <= 1'b0;
      change_irq_q <= 1'b0;
      change_slot_q <= `SCP_BYTE_RESET;
    end else begin
      change_push_q <= sig_report;
      change_irq_q <= sig_report;
      if (sig_report) change_slot_q <= 8'(odd_slot);
    end
  end

endmodule : scp_core
`default_nettype wire

// ### tb/scp_checker.sv
// Port assertions for the signaling channel preprocessor core.
// Assumes binding into scp_core; it sees that module's ports only.
`timescale 1ns/10ps
`default_nettype none
module scp_checker #(parameter int SLOT_AW = 7, parameter int PW = 4) (
  input wire logic clk,
  input wire logic rst,
  input wire logic addr_reg_we,
  input wire logic [7:0] addr_reg_wdata,
  input wire logic command_reg_we,
  input wire logic slot_strobe,
  input wire logic [SLOT_AW-1:0] slot_index,
  input wire logic down_valid_q,
  input wire logic pcm_up_valid_q,
  input wire logic [7:0] pcm_up_oe_q,
  input wire logic change_push_q,
  input wire logic [7:0] change_slot_q,
  input wire logic change_irq_q,
  input wire logic [7:0] read_data_q,
  input wire logic [7:0] mem_access_addr_reg_q
);
  // *****
  // Results tied to their causes
  // *****
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_down_from_slot: assert property (
    down_valid_q |-> $past(slot_strobe)) else $error("Stray down byte");
  a_irq_with_push: assert property (
    change_irq_q == change_push_q) else $error("Irq and push differ");
  a_push_odd_slot: assert property (
    change_push_q |-> $past(slot_strobe && slot_index[0]))
    else $error("Change without odd slot");
  a_report_slot: assert property (
    change_push_q |-> change_slot_q[SLOT_AW-1:0] == $past(slot_index))
    else $error("Wrong reported slot");
  a_pcm_up_odd: assert property (
    pcm_up_valid_q |-> $past(slot_strobe && slot_index[0]))
    else $error("PCM byte without odd slot");
  a_oe_upper_on: assert property (
    pcm_up_valid_q |-> pcm_up_oe_q[7:2] == 6'h3f &&
    pcm_up_oe_q[1] == pcm_up_oe_q[0]) else $error("Bad enable");
  a_addr_loaded: assert property (
    addr_reg_we |=> mem_access_addr_reg_q == $past(addr_reg_wdata))
    else $error("Address byte not loaded");
  a_read_holds: assert property (
    !command_reg_we |=> $stable(read_data_q)) else $error("Read moved");
  c_change: cover property (change_push_q);
  c_float: cover property (pcm_up_valid_q && !pcm_up_oe_q[0]);
  c_down: cover property (down_valid_q);
endmodule : scp_checker
bind scp_core scp_checker #(.SLOT_AW(SLOT_AW), .PW(PW)) u_chk (.*);
`default_nettype wire

// ### tb/scp_far_end.sv
// Far end: codec on the subscriber slots and PCM source memory.
// Assumes the bench supplies the codec's current signaling byte.
`timescale 1ns/10ps
`default_nettype none
module scp_far_end (
  input wire logic slot_strobe,
  input wire logic [7:0] sig_value,
  input wire logic [7:0] pcm_down_ptr,
  output logic [7:0] up_byte,
  output logic [7:0] pcm_down_byte
);
  // *****
  // Line drivers
  // *****
  // Outside its slot the line shows the inverse, so stale data is caught
  assign up_byte = slot_strobe ? sig_value : ~sig_value;
  // Low two bits held at one so the handshake AND passes them through
  assign pcm_down_byte = {pcm_down_ptr[5:0] ^ 6'h15, 2'h3};
endmodule : scp_far_end
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench of scp_core with its far end and checker.
// Assumes scp_core, scp_checker and scp_far_end compile before it.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk, rst, data_reg_we, addr_reg_we, command_reg_we, frame_start;
  logic monitor_handshake_en, slot_strobe, down_valid_q, pcm_up_valid_q;
  logic change_push_q, change_irq_q;
  logic [7:0] data_reg_wdata, addr_reg_wdata, command_reg_wdata, r, hs8;
  logic [7:0] read_data_q, mem_access_addr_reg_q, monitor_tx_byte, sigv;
  logic [7:0] up_byte, down_byte_q, pcm_down_ptr, pcm_down_byte;
  logic [7:0] pcm_up_ptr_q, pcm_up_byte_q, pcm_up_oe_q, change_slot_q;
  logic [3:0] sample_period;
  logic [1:0] monitor_hs_bits;
  logic [6:0] slot_index;
  int errors, total_checks, cnt, hit, act, stab;
  logic [7:0] seq [$];
  // Pairs 2/3 six-bit, 4/5 eight-bit, 6/7 switched to the PCM side
  logic [7:0] pa [12] = '{8'h02, 8'h03, 8'h82, 8'h83, 8'h04, 8'h05,
    8'h84, 8'h85, 8'h06, 8'h07, 8'h86, 8'h87};
  logic [3:0] pc [12] = '{4'ha, 4'hb, 4'ha, 4'ha, 4'ha, 4'hb, 4'hb,
    4'hb, 4'ha, 4'h1, 4'ha, 4'h1};
  logic [7:0] pd [12] = '{8'h47, 8'h00, 8'hdc, 8'hdc, 8'h45, 8'h00,
    8'hd6, 8'hd6, 8'h00, 8'h21, 8'h00, 8'h42};

  scp_core u_dut (.*);
  scp_far_end u_far (.slot_strobe(slot_strobe), .sig_value(sigv),
    .pcm_down_ptr(pcm_down_ptr), .up_byte(up_byte),
    .pcm_down_byte(pcm_down_byte));

  // *****
  // Clock and shared tasks
  // *****
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic chk(logic [7:0] got, logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Data, address, then command, one cycle each
  task automatic cmd(logic [7:0] a, logic [7:0] c, logic [7:0] d);
    data_reg_we = 1;
    data_reg_wdata = d;
    step();
    data_reg_we = 0;
    addr_reg_we = 1;
    addr_reg_wdata = a;
    step();
    addr_reg_we = 0;
    command_reg_we = 1;
    command_reg_wdata = c;
    step();
    command_reg_we = 0;
  endtask : cmd

  task automatic rd(logic [7:0] a, logic [7:0] e);
    cmd(a, 8'h40, 8'h00);
    step();
    chk(read_data_q, e);
    chk(mem_access_addr_reg_q, a);
  endtask : rd

  // Idle cycle first so the strobe never toggles within one time step
  task automatic slot(logic [6:0] i);
    step();
    slot_strobe = 1;
    slot_index = i;
    step();
    slot_strobe = 0;
  endtask : slot

  // One frame; the model predicts changes only when every frame samples
  task automatic frame(logic [6:0] i, logic [7:0] m);
    int s;
    logic e;
    frame_start = 1;
    step();
    frame_start = 0;
    slot(i);
    s = sigv & m;
    e = s == act && s != stab;
    cnt++;
    if (sample_period == 0) begin
      chk({7'h0, change_push_q}, {7'h0, e});
      chk({7'h0, change_irq_q}, {7'h0, e});
      if (e) stab = s;
      act = s;
    end
    if (change_push_q === 1'b1) begin
      if (hit == 0) hit = cnt;
      chk({1'b0, change_slot_q[6:0]}, {1'b0, i});
    end
  endtask : frame

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Cuts a hang short
  initial begin
    #200000;
    errors++;
    end_of_test();
  end

  // *****
  // Main sequence
  // *****
  initial begin
    rst = 1;
    {data_reg_we, addr_reg_we, command_reg_we, frame_start} = '0;
    {slot_strobe, monitor_handshake_en, sample_period} = '0;
    {data_reg_wdata, addr_reg_wdata, command_reg_wdata} = '0;
    {monitor_tx_byte, monitor_hs_bits, slot_index, sigv} = '0;
    void'($urandom(32'hb708));
    repeat (10) @(posedge clk);
    #1;
    rst = 0;
    rd(8'h02, 8'h00);
    foreach (pa[k]) cmd(pa[k], {4'h7, pc[k]}, pd[k]);
    cmd(8'h42, 8'h60, 8'h00);
    cmd(8'h04, 8'h3b, 8'h99);
    foreach (pa[k]) rd(pa[k], pd[k]);
    $display("memory access test done");
    for (int h = 0; h < 4; h++) begin
      monitor_handshake_en = h[0];
      {monitor_tx_byte, monitor_hs_bits} = 10'($urandom);
      hs8 = {6'h0, h[0] ? monitor_hs_bits : 2'h3};
      sigv = 8'hdc;
      slot(7'h02);
      chk({7'h0, down_valid_q}, 8'h01);
      chk(down_byte_q, monitor_tx_byte);
      slot(7'h03);
      chk(down_byte_q, 8'h44 | hs8);
      sigv = 8'hd6;
      monitor_handshake_en = 1'b0;
      slot(7'h05);
      chk(down_byte_q, 8'h45);
      monitor_handshake_en = h[0];
      slot(7'h07);
      chk(down_byte_q, 8'hd0 | hs8);
      chk(pcm_down_ptr, 8'h21);
      chk({7'h0, pcm_up_valid_q}, 8'h01);
      chk(pcm_up_ptr_q, 8'h42);
      chk(pcm_up_byte_q, 8'hd6);
      chk(pcm_up_oe_q, 8'hfc);
    end
    cmd(8'h42, 8'h60, 8'h01);
    slot(7'h07);
    chk(pcm_up_oe_q, 8'hff);
    slot(7'h10);
    chk({7'h0, down_valid_q}, 8'h00);
    $display("downstream test done");
    // Low bits only, a one-frame glitch, then a real change
    r = {6'h37 ^ (6'($urandom) | 6'h01), 2'($urandom)};
    seq = '{8'hdd, 8'h50, 8'hdc, r, r, r};
    act = 8'hdc;
    stab = 8'hdc;
    foreach (seq[k]) begin
      sigv = seq[k];
      frame(7'h03, 8'hfc);
    end
    rd(8'h82, r & 8'hfc);
    rd(8'h83, r & 8'hfc);
    sample_period = 4'h1;
    monitor_handshake_en = 1'b0;
    r = 8'hd6 ^ (8'($urandom) | 8'h01);
    sigv = r;
    hit = 0;
    cnt = 0;
    repeat (6) frame(7'h05, 8'hff);
    chk({7'h0, hit == 3 || hit == 4}, 8'h01);
    rd(8'h85, r);
    $display("upstream test done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
